// File: common/port_pin_state_pkg.sv
package gpio_pkg;

    // Register offsets are word indices; byte address is four times the index
    localparam int          ADDR_W          = 18;
    localparam logic [15:0] IDX_DIRECTION   = 16'hfebe;
    localparam logic [15:0] IDX_OUTPUT_DATA = 16'hff6e;
    localparam logic [15:0] IDX_PIN_STATE   = 16'hff5e;

    localparam logic [7:0]  DIR_RESET_EXT   = 8'h80;
    localparam logic [7:0]  DIR_RESET_SC    = 8'h00;
    localparam logic [7:0]  ODR_RESET       = 8'h00;
    localparam logic [7:0]  DIR_READ_VALUE  = 8'h00;
    localparam logic [7:0]  HELD_RESET      = 8'hff;

    // Pins 6..3 and 1 are the bus-control outputs kept or floated in standby
    localparam logic [7:0]  BUSCTL_OUT_MASK = 8'h7a;

    localparam int          PIN_CLK         = 7;
    localparam int          PIN_STRETCH     = 2;
    localparam int          PIN_ACK         = 1;
    localparam int          PIN_REQ         = 0;

    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    localparam logic [2:0]  MODE_1          = 3'h1;
    localparam logic [2:0]  MODE_2          = 3'h2;
    localparam logic [2:0]  MODE_4          = 3'h4;
    localparam logic [2:0]  MODE_5          = 3'h5;
    localparam logic [2:0]  MODE_6          = 3'h6;

    function automatic logic is_ext_mode(input logic [2:0] mode);
        is_ext_mode = (mode == MODE_1) || (mode == MODE_2) || (mode == MODE_4)
                   || (mode == MODE_5) || (mode == MODE_6);
    endfunction : is_ext_mode

endpackage : gpio_pkg

// File: logic/pin_mux_slice.sv
`timescale 1ns/1ps
module pin_mux_slice (
    input  wire logic gpio_dir,  // Direction bit, 1 = output
    input  wire logic gpio_val,  // Output data bit
    input  wire logic alt_sel,   // Alternate function owns the pin
    input  wire logic alt_oe,    // Alternate function drives the pin
    input  wire logic alt_val,   // Alternate function level
    output logic      pin_oe,    // Pin driver enable
    output logic      pin_out    // Pin driven level
);

    // Alternate function overrides the direction bit entirely
    always_comb begin
        if (alt_sel) begin
            pin_oe  = alt_oe;
            pin_out = alt_val;
        end else begin
            pin_oe  = gpio_dir;
            pin_out = gpio_val;
        end
    end

endmodule : pin_mux_slice

// File: logic/port_f_gpio.sv
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
// Behaviour
// - Direction register is write-only; reads return a fixed value, not the bits.
// - Reset or hardware standby loads direction 80h in bus modes, 00h otherwise.
// - Direction and output data survive manual reset and software standby.
// - Pin 7 outputs system clock when its direction bit is 1, else input.
// - Bus modes: pins 6..3 are fixed strobe outputs, direction bits ignored.
// - Bus modes: pins 2..0 take bus functions when enabled, else plain GPIO.
// - Single-chip modes: direction 1 gives output, 0 gives input, per pin.
// - Output data register is read/write, drives GPIO outputs, resets to zero.
// - Pin state register is read-only; writes are ignored.
// - Pin state read gives output data where direction 1, pin level where 0.
// - Pin state tracks pins after reset; holds in manual reset, software standby.
// - In software standby, bus-control outputs hold or float per keep bit.
// - Bus modes: pin 2 stretch input, pins 1/0 acknowledge/request when enabled.
module port_f_gpio (
    input  wire logic        mclk,                   // System clock, 10 MHz
    input  wire logic        rst,                    // Power-on reset, sync, high
    input  wire logic        ce,                     // Clock enable, freezes state
    input  wire logic        manual_reset,           // Manual reset, state retained
    input  wire logic        hw_standby,             // Hardware standby, initialises
    input  wire logic        sw_standby,             // Software standby, state retained
    input  wire logic [2:0]  op_mode,                // Operating mode 0..7
    input  wire logic        stretch_pin_enable,     // Bus controller wait enable
    input  wire logic        bus_release_enable,     // Bus controller release enable
    input  wire logic        standby_output_keep,    // 1 = hold bus outputs in standby
    input  wire logic        sys_clk_level,          // Clock level for pin 7
    input  wire logic        address_strobe_src,     // Strobe from bus controller
    input  wire logic        read_strobe_src,        // Strobe from bus controller
    input  wire logic        upper_write_src,        // Strobe from bus controller
    input  wire logic        lower_write_src,        // Strobe from bus controller
    input  wire logic        bus_ack_src,            // Acknowledge from bus controller
    input  wire logic [7:0]  pin_in,                 // Pin input levels
    output logic      [7:0]  pin_out,                // Pin output levels
    output logic      [7:0]  pin_oe,                 // Pin drive enables, high drives
    output logic             address_strobe_out,     // Copy of pin 6 drive level
    output logic             upper_write_strobe_out, // Copy of pin 4 drive level
    output logic             lower_write_strobe_out, // Copy of pin 3 drive level
    output logic             stretch_in,             // Wait input, high when unused
    output logic             bus_grant_request_in,   // Request input, high when unused
    output logic             ext_int_in0,            // Interrupt level, pin 0
    output logic             ext_int_in1,            // Interrupt level, pin 1
    output logic             ext_int_in2,            // Interrupt level, pin 2
    output logic             ext_int_in3,            // Interrupt level, pin 3
    input  wire logic [gpio_pkg::ADDR_W-1:0] s_axi_awaddr,   // Write address
    input  wire logic        s_axi_awvalid,          // Write address valid
    output logic             s_axi_awready,          // Write address ready
    input  wire logic [31:0] s_axi_wdata,            // Write data
    input  wire logic [3:0]  s_axi_wstrb,            // Write byte strobes
    input  wire logic        s_axi_wvalid,           // Write data valid
    output logic             s_axi_wready,           // Write data ready
    output logic      [1:0]  s_axi_bresp,            // Write response
    output logic             s_axi_bvalid,           // Write response valid
    input  wire logic        s_axi_bready,           // Write response ready
    input  wire logic [gpio_pkg::ADDR_W-1:0] s_axi_araddr,   // Read address
    input  wire logic        s_axi_arvalid,          // Read address valid
    output logic             s_axi_arready,          // Read address ready
    output logic      [31:0] s_axi_rdata,            // Read data
    output logic      [1:0]  s_axi_rresp,            // Read response
    output logic             s_axi_rvalid,           // Read data valid
    input  wire logic        s_axi_rready            // Read data ready
);

    logic [7:0]  dir_ff;
    logic [7:0]  odr_ff;
    logic [7:0]  pin_state_ff;
    logic [7:0]  held_ff;
    logic        aw_held_ff;
    logic        w_held_ff;
    logic [15:0] waddr_idx_ff;
    logic [7:0]  wdata_ff;
    logic        wstrb0_ff;
    logic        bvalid_ff;
    logic [1:0]  bresp_ff;
    logic        rvalid_ff;
    logic [7:0]  rdata_ff;
    logic [1:0]  rresp_ff;
    logic        rd_was_dir_ff;

    logic        ext_mode;
    logic        init_regs;
    logic        wr_do;
    logic        wr_dir;
    logic        wr_odr;
    logic        wr_known;
    logic        rd_do;
    logic [15:0] raddr_idx;
    logic [7:0]  nxt_rdata;
    logic        rd_known;
    logic [7:0]  pin_state_view;
    logic [7:0]  dir_reset;
    logic [7:0]  alt_sel;
    logic [7:0]  alt_oe;
    logic [7:0]  alt_val;
    logic [7:0]  mux_oe;
    logic [7:0]  mux_out;
    logic [7:0]  float_mask;
    logic [7:0]  keep_mask;

    assign ext_mode  = gpio_pkg::is_ext_mode(op_mode);
    assign init_regs = rst || hw_standby;
    assign dir_reset = ext_mode ? gpio_pkg::DIR_RESET_EXT : gpio_pkg::DIR_RESET_SC;

    // AXI4-Lite write side: address and data taken in either order
    assign s_axi_awready = ce && !aw_held_ff && !bvalid_ff;
    assign s_axi_wready  = ce && !w_held_ff && !bvalid_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign wr_do         = ce && aw_held_ff && w_held_ff && !bvalid_ff;

    assign wr_known = (waddr_idx_ff == gpio_pkg::IDX_DIRECTION)
                   || (waddr_idx_ff == gpio_pkg::IDX_OUTPUT_DATA)
                   || (waddr_idx_ff == gpio_pkg::IDX_PIN_STATE);
    // Writes while the chip sits in manual reset are answered but dropped
    assign wr_dir = wr_do && wstrb0_ff && !manual_reset
                 && (waddr_idx_ff == gpio_pkg::IDX_DIRECTION);
    assign wr_odr = wr_do && wstrb0_ff && !manual_reset
                 && (waddr_idx_ff == gpio_pkg::IDX_OUTPUT_DATA);

    always_ff @(posedge mclk) begin
        if (rst) begin
            aw_held_ff   <= 1'b0;
            waddr_idx_ff <= 16'h0000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_ff   <= 1'b1;
            waddr_idx_ff <= s_axi_awaddr[gpio_pkg::ADDR_W-1:2];
        end else if (wr_do) begin
            aw_held_ff   <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            w_held_ff <= 1'b0;
            wdata_ff  <= 8'h00;
            wstrb0_ff <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_ff <= 1'b1;
            wdata_ff  <= s_axi_wdata[7:0];
            wstrb0_ff <= s_axi_wstrb[0];
        end else if (wr_do) begin
            w_held_ff <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= gpio_pkg::RESP_OKAY;
        end else if (ce) begin
            if (wr_do) begin
                bvalid_ff <= 1'b1;
                // Pin state write is legal but has no effect
                bresp_ff  <= wr_known ? gpio_pkg::RESP_OKAY : gpio_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // Registers: power-on reset and hardware standby initialise, nothing else does
    always_ff @(posedge mclk) begin
        if (init_regs) begin
            dir_ff <= dir_reset;
        end else if (ce && wr_dir) begin
            dir_ff <= wdata_ff;
        end
    end

    always_ff @(posedge mclk) begin
        if (init_regs) begin
            odr_ff <= gpio_pkg::ODR_RESET;
        end else if (ce && wr_odr) begin
            odr_ff <= wdata_ff;
        end
    end

    // Sampled pin levels freeze through manual reset and software standby
    always_ff @(posedge mclk) begin
        if (init_regs) begin
            pin_state_ff <= pin_in;
        end else if (ce && !manual_reset && !sw_standby) begin
            pin_state_ff <= pin_in;
        end
    end

    assign pin_state_view = (odr_ff & dir_ff) | (pin_state_ff & ~dir_ff);

    // AXI4-Lite read side, one read in flight
    assign s_axi_arready = ce && !rvalid_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = {24'h00_0000, rdata_ff};
    assign s_axi_rresp   = rresp_ff;
    assign rd_do         = s_axi_arvalid && s_axi_arready;
    assign raddr_idx     = s_axi_araddr[gpio_pkg::ADDR_W-1:2];

    always_comb begin
        nxt_rdata = 8'h00;
        rd_known  = 1'b1;
        unique case (raddr_idx)
            gpio_pkg::IDX_DIRECTION:   nxt_rdata = gpio_pkg::DIR_READ_VALUE;
            gpio_pkg::IDX_OUTPUT_DATA: nxt_rdata = odr_ff;
            gpio_pkg::IDX_PIN_STATE:   nxt_rdata = pin_state_view;
            default:                    rd_known  = 1'b0;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rvalid_ff     <= 1'b0;
            rdata_ff      <= 8'h00;
            rresp_ff      <= gpio_pkg::RESP_OKAY;
            rd_was_dir_ff <= 1'b0;
        end else if (ce) begin
            if (rd_do) begin
                rvalid_ff     <= 1'b1;
                rdata_ff      <= nxt_rdata;
                rresp_ff      <= rd_known ? gpio_pkg::RESP_OKAY : gpio_pkg::RESP_SLVERR;
                rd_was_dir_ff <= (raddr_idx == gpio_pkg::IDX_DIRECTION);
            end else if (s_axi_rready) begin
                rvalid_ff     <= 1'b0;
            end
        end
    end

    // Pin function selection, re-evaluated every cycle from static settings
    always_comb begin
        alt_sel = 8'h00;
        alt_oe  = 8'h00;
        alt_val = 8'h00;
        alt_sel[gpio_pkg::PIN_CLK] = dir_ff[gpio_pkg::PIN_CLK];
        alt_oe[gpio_pkg::PIN_CLK]  = 1'b1;
        alt_val[gpio_pkg::PIN_CLK] = sys_clk_level;
        alt_sel[6:3] = {4{ext_mode}};
        alt_oe[6:3]  = 4'hf;
        alt_val[6:3] = {address_strobe_src, read_strobe_src,
                        upper_write_src, lower_write_src};
        alt_sel[gpio_pkg::PIN_STRETCH] = ext_mode && stretch_pin_enable;
        alt_sel[gpio_pkg::PIN_ACK]     = ext_mode && bus_release_enable;
        alt_oe[gpio_pkg::PIN_ACK]      = 1'b1;
        alt_val[gpio_pkg::PIN_ACK]     = bus_ack_src;
        alt_sel[gpio_pkg::PIN_REQ]     = ext_mode && bus_release_enable;
    end

    // Unselected pins fall back to direction bit and output data
    for (genvar i = 0; i < 8; i++) begin : g_pin
        pin_mux_slice u_slice (
            .gpio_dir (dir_ff[i]),
            .gpio_val (odr_ff[i]),
            .alt_sel  (alt_sel[i]),
            .alt_oe   (alt_oe[i]),
            .alt_val  (alt_val[i]),
            .pin_oe   (mux_oe[i]),
            .pin_out  (mux_out[i])
        );
    end

    // Last driven bus-control levels, replayed while standby keeps outputs
    always_ff @(posedge mclk) begin
        if (init_regs) begin
            held_ff <= gpio_pkg::HELD_RESET;
        end else if (ce && !sw_standby) begin
            held_ff <= mux_out;
        end
    end

    assign keep_mask  = (sw_standby && standby_output_keep)
                      ? (alt_sel & gpio_pkg::BUSCTL_OUT_MASK) : 8'h00;
    assign float_mask = (sw_standby && !standby_output_keep)
                      ? (alt_sel & gpio_pkg::BUSCTL_OUT_MASK) : 8'h00;
    assign pin_oe     = mux_oe & ~float_mask;
    assign pin_out    = (held_ff & keep_mask) | (mux_out & ~keep_mask);

    assign address_strobe_out     = pin_out[6];
    assign upper_write_strobe_out = pin_out[4];
    assign lower_write_strobe_out = pin_out[3];

    // Unused bus inputs idle inactive high so the controller never sees a request
    assign stretch_in           = alt_sel[gpio_pkg::PIN_STRETCH]
                                ? pin_in[gpio_pkg::PIN_STRETCH] : 1'b1;
    assign bus_grant_request_in = alt_sel[gpio_pkg::PIN_REQ]
                                ? pin_in[gpio_pkg::PIN_REQ] : 1'b1;
    // Interrupt logic sees raw levels; software keeps these pins as inputs
    assign ext_int_in0 = pin_in[0];
    assign ext_int_in1 = pin_in[1];
    assign ext_int_in2 = pin_in[2];
    assign ext_int_in3 = pin_in[3];

    chk_dir_read_hidden: assert property (@(posedge mclk) disable iff (rst)
        s_axi_rvalid && rd_was_dir_ff |-> s_axi_rdata[7:0] == gpio_pkg::DIR_READ_VALUE)
        else $error("direction read leaked stored bits");

    chk_dir_reset_value: assert property (@(posedge mclk) disable iff (rst)
        $past(rst) |-> dir_ff == (ext_mode ? 8'h80 : 8'h00))
        else $error("direction reset value wrong for mode");

    chk_regs_retained: assert property (@(posedge mclk) disable iff (rst)
        manual_reset && !hw_standby |=> $stable(dir_ff) && $stable(odr_ff))
        else $error("registers changed during manual reset");

    chk_clock_pin_out: assert property (@(posedge mclk) disable iff (rst)
        dir_ff[7] |-> pin_oe[7] && pin_out[7] == sys_clk_level)
        else $error("pin 7 not driving clock");

    chk_strobe_pins_fixed: assert property (@(posedge mclk) disable iff (rst)
        ext_mode && !sw_standby |-> pin_oe[6:3] == 4'hf
            && pin_out[6:3] == {address_strobe_src, read_strobe_src,
                                upper_write_src, lower_write_src})
        else $error("strobe pins not driven in bus mode");

    chk_stretch_pin_input: assert property (@(posedge mclk) disable iff (rst)
        ext_mode && stretch_pin_enable |-> !pin_oe[2] && stretch_in == pin_in[2])
        else $error("wait pin not an input");

    chk_gpio_fallback: assert property (@(posedge mclk) disable iff (rst)
        ext_mode && !bus_release_enable |-> pin_oe[1:0] == dir_ff[1:0]
            && bus_grant_request_in)
        else $error("pins 1..0 not following direction bits");

    chk_single_chip_dir: assert property (@(posedge mclk) disable iff (rst)
        !ext_mode |-> pin_oe == dir_ff)
        else $error("single-chip drive enables differ from direction");

    chk_odr_drives_pins: assert property (@(posedge mclk) disable iff (rst)
        !ext_mode |-> ((pin_out ^ odr_ff) & dir_ff & 8'h7f) == 8'h00)
        else $error("output pin level differs from output data");

    chk_pin_state_ro: assert property (@(posedge mclk) disable iff (rst)
        wr_do && waddr_idx_ff == gpio_pkg::IDX_PIN_STATE && !hw_standby
            |=> $stable(dir_ff) && $stable(odr_ff) && s_axi_bvalid)
        else $error("pin state write had an effect");

    chk_pin_state_read: assert property (@(posedge mclk) disable iff (rst)
        rd_do && raddr_idx == gpio_pkg::IDX_PIN_STATE
            |=> ((s_axi_rdata[7:0] ^ $past(odr_ff)) & $past(dir_ff)) == 8'h00)
        else $error("pin state read ignores output data");

    chk_pin_state_hold: assert property (@(posedge mclk) disable iff (rst)
        (sw_standby || manual_reset) && !hw_standby |=> $stable(pin_state_ff))
        else $error("pin state changed in standby");

    chk_standby_float: assert property (@(posedge mclk) disable iff (rst)
        sw_standby && !standby_output_keep && ext_mode |-> pin_oe[6:3] == 4'h0)
        else $error("bus outputs not floated in standby");

endmodule : port_f_gpio

// File: test/pin_board.sv
`timescale 1ns/1ps
module pin_board (
    input  wire logic [7:0] pin_out,   // Device drive levels
    input  wire logic [7:0] pin_oe,    // Device drive enables
    input  wire logic [7:0] ext_level, // Board level on undriven lines
    output logic      [7:0] pin_in     // Resolved line levels
);
    // Undriven lines take the board level, never a stale device value
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : pin_board

// File: test/tb_port_f_gpio.sv
`timescale 1ns/1ps
module tb_port_f_gpio;
    localparam logic [17:0] A_DIR = {gpio_pkg::IDX_DIRECTION, 2'b00};
    localparam logic [17:0] A_ODR = {gpio_pkg::IDX_OUTPUT_DATA, 2'b00};
    localparam logic [17:0] A_PIN = {gpio_pkg::IDX_PIN_STATE, 2'b00};
    localparam logic [7:0]  BUSM  = 8'h76;
    logic        mclk, rst, ms, hws, sws, sre, bre, keep, sclk, as_s, rd_s, uw_s, lw_s, ack_s;
    logic [2:0]  mode;
    logic [7:0]  pin_out, pin_oe, pin_in, ext, d, o, e;
    logic [3:0]  lv;
    logic        asto, uwo, lwo, st_in, brq, i0, i1, i2, i3;
    logic [17:0] awaddr, araddr;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, rd;
    logic [1:0]  bresp, rresp, resp;
    int          failures, total_checks, seed;

    port_f_gpio DUT (.mclk(mclk), .rst(rst), .ce(1'b1), .manual_reset(ms), .hw_standby(hws),
        .sw_standby(sws), .op_mode(mode), .stretch_pin_enable(sre), .bus_release_enable(bre),
        .standby_output_keep(keep), .sys_clk_level(sclk), .address_strobe_src(as_s),
        .read_strobe_src(rd_s), .upper_write_src(uw_s), .lower_write_src(lw_s),
        .bus_ack_src(ack_s), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .address_strobe_out(asto), .upper_write_strobe_out(uwo), .lower_write_strobe_out(lwo),
        .stretch_in(st_in), .bus_grant_request_in(brq), .ext_int_in0(i0), .ext_int_in1(i1),
        .ext_int_in2(i2), .ext_int_in3(i3), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    pin_board board (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext), .pin_in(pin_in));

    always #50 mclk = ~mclk;
    always @(posedge mclk) begin
        sclk <= ~sclk;
        {as_s, rd_s, uw_s, lw_s, ack_s} <= 5'($random(seed));
    end

    task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t %s", $time, msg);
        end
    endtask : chk

    // Both bus tasks start on a fresh edge and wait only for the answer
    task wr(input logic [17:0] a, input logic [7:0] v);
        int n;
        logic done;
        n = 0;
        done = 0;
        resp = 2'bxx;
        @(posedge mclk);
        awaddr <= a;
        wdata <= {24'h00_0000, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done && n < 50) begin
            @(posedge mclk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                resp = bresp;
                bready <= 1'b0;
                done = 1;
            end
        end
        chk(done, 1'b1, "write answer");
    endtask : wr

    task rdr(input logic [17:0] a);
        int n;
        logic done;
        n = 0;
        done = 0;
        rd = 'x;
        resp = 2'bxx;
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done && n < 50) begin
            @(posedge mclk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                rd = rdata;
                resp = rresp;
                rready <= 1'b0;
                done = 1;
            end
        end
        chk(done, 1'b1, "read answer");
    endtask : rdr

    task rst_to(input logic [2:0] m, input logic s, input logic b);
        @(posedge mclk);
        rst <= 1'b1;
        mode <= m;
        sre <= s;
        bre <= b;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        #1;
    endtask : rst_to

    function automatic logic [7:0] exp_oe(input logic [2:0] m, input logic [7:0] dr,
                                          input logic s, input logic b);
        logic [7:0] r;
        r = dr;
        if (BUSM[m]) begin
            r[6:3] = 4'hf;
            if (s) r[2] = 1'b0;
            if (b) r[1:0] = 2'b10;
        end
        return r;
    endfunction : exp_oe

    task results;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : results

    initial begin
        #(3000 * 100);
        failures++;
        $display("CHECK FAILED t=%0t watchdog", $time);
        results();
    end

    initial begin
        {mclk, ms, hws, sws, sre, bre, keep, sclk, as_s, rd_s, uw_s, lw_s, ack_s} = '0;
        {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
        rst = 1;
        mode = 0;
        ext = 8'h00;
        seed = 58;
        for (int m = 0; m < 8; m++) begin
            rst_to(3'(m), 0, 0);
            chk(pin_oe, exp_oe(3'(m), BUSM[m] ? 8'h80 : 8'h00, 0, 0), "reset oe");
            rdr(A_ODR);
            chk(rd, 0, "odr reset");
            rdr(A_DIR);
            chk(rd, {24'h00_0000, gpio_pkg::DIR_READ_VALUE}, "dir read");
        end
        $display("test reset per mode done");
        rst_to(3'h7, 0, 0);
        for (int i = 0; i < 6; i++) begin
            d = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
            o = 8'($random(seed));
            e = 8'($random(seed));
            @(posedge mclk);
            ext <= e;
            wr(A_DIR, d);
            wr(A_ODR, o);
            #1;
            chk(pin_oe, d, "single chip oe");
            chk(pin_out & d & 8'h7f, o & d & 8'h7f, "gpio out");
            if (d[7]) chk(pin_out[7], sclk, "clock out");
            rdr(A_PIN);
            chk(rd, {24'h00_0000, (d & o) | (~d & e)}, "pin state");
        end
        wr(A_PIN, ~o);
        chk(resp, gpio_pkg::RESP_OKAY, "pin state write");
        rdr(A_ODR);
        chk(rd, {24'h00_0000, o}, "odr kept");
        chk(resp, gpio_pkg::RESP_OKAY, "read response");
        wr(18'h0_0010, 8'h5a);
        chk(resp, gpio_pkg::RESP_SLVERR, "unmapped");
        rdr(18'h0_0010);
        chk(resp, gpio_pkg::RESP_SLVERR, "unmapped read");
        $display("test single chip done");
        wr(A_DIR, 8'h0f);
        wr(A_ODR, 8'h3c);
        @(posedge mclk);
        ext <= 8'ha5;
        repeat (2) @(posedge mclk);
        ms <= 1'b1;
        ext <= 8'h5a;
        wr(A_ODR, 8'hc3);
        rdr(A_ODR);
        chk(rd, 32'h0000_003c, "odr in manual reset");
        rdr(A_PIN);
        chk(rd, 32'h0000_00ac, "pin state held");
        @(posedge mclk);
        ms <= 1'b0;
        rdr(A_PIN);
        chk(rd, 32'h0000_005c, "pin state tracks");
        @(posedge mclk);
        hws <= 1'b1;
        repeat (2) @(posedge mclk);
        hws <= 1'b0;
        rdr(A_ODR);
        chk(rd, 0, "odr after hw standby");
        #1;
        chk(pin_oe, 8'h00, "dir after hw standby");
        $display("test reset kinds done");
        rst_to(3'h1, 1, 1);
        chk(pin_oe, exp_oe(3'h1, 8'h80, 1, 1), "bus oe");
        chk(pin_out[1], ack_s, "acknowledge out");
        chk({st_in, brq}, {pin_in[2], pin_in[0]}, "bus inputs");
        chk({i3, i2, i1, i0}, pin_in[3:0], "interrupt levels");
        chk({asto, pin_out[5], uwo, lwo}, {as_s, rd_s, uw_s, lw_s}, "strobes");
        lv = pin_out[6:3];
        @(posedge mclk);
        sws <= 1'b1;
        keep <= 1'b1;
        @(posedge mclk);
        #1;
        chk({pin_oe[6:3], pin_out[6:3]}, {4'hf, lv}, "standby keep");
        @(posedge mclk);
        keep <= 1'b0;
        @(posedge mclk);
        #1;
        chk(pin_oe[6:3], 4'h0, "standby float");
        @(posedge mclk);
        sws <= 1'b0;
        rst_to(3'h1, 0, 0);
        wr(A_DIR, 8'h07);
        #1;
        chk(pin_oe, exp_oe(3'h1, 8'h07, 0, 0), "bus gpio oe");
        chk({st_in, brq}, 2'b11, "bus inputs idle");
        $display("test bus modes done");
        results();
    end
endmodule : tb_port_f_gpio
